// ### rtl/hub_ccc_capability_hid_device_control_cmd.sv
// Capability query, host identifier set and device control command interpreter.

// Behaviour
// [R1] Capability query acted on only in I3C Basic mode; ignored in I2C mode.
// [R2] Checksum restarts at Start or Repeat Start and skips broadcast write byte.
// [R3] Capability read: Sr, own identifier with read, upper, lower, optional checksum.
// [R4] After a parity error in a chained transaction the address is not acknowledged.
// [R5] Upper capability byte has only bit 2 set; lower byte is all zero.
// [R6] Host identifier set accepted in I2C mode, flagged illegal in I3C mode.
// [R7] Host keeps the bus at or below 1 MHz for these commands in I2C.
// [R8] After host identifier set, identifier translation toward the local bus stops.
// [R9] Host sends broadcast write, code 0x61, one zero data byte, then Stop.
// [R10] Forwarded byte keeps bits 7 to 4 and 0, bits 3 to 1 become host identifier.
// [R11] Parity is recomputed over the forwarded byte and sent as its T bit.
// [R12] Host identifier set never expects or produces a checksum byte.
// [R13] Repeated host identifier set commands are each handled the same way.
// [R14] Device control command accepted in both I2C and I3C Basic modes.
// [R15] Device control frame: code 0x62, control byte, target identifier, payload bytes.
// [R16] Host honours device specific register restrictions when register mode is one.
// [R17] In I2C, host uses device control only with single byte addressing mode.
// [R18] Mask 000 unicast full match, 011 multicast upper four bits, 111 all devices.
// [R19] Start byte field picks first payload byte; following bytes continue up to three.
// [R20] With checksum on and register mode zero, checksum follows burst length bytes.
// [R21] Reserved address mask encodings are ignored until Stop or Repeat Start.
module hub_ccc_capability_hid_device_control_cmd
	import hub_ccc_pkg::*;
#(
	parameter logic [7:0] capability_code = 8'he0
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic i3c_mode,
	input wire logic pec_enable,
	input wire logic [2:0] host_identifier,
	input wire logic [3:0] local_identifier,
	output logic hid_translate,
	output fwd_s fwd,
	output dc_write_s wr,
	output logic illegal_cmd,
	output logic parity_error,
	output logic pec_error
);

	typedef struct packed {
		cmd_state_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] crc;
		logic [7:0] tx;
		logic [1:0] tidx;
		logic drive;
		logic sda_bit;
		logic err;
		logic pend_cap;
		logic hid_done;
		logic rmode;
		logic [1:0] idx;
		logic [1:0] nb;
		logic [1:0] bl;
		logic [2:0] amask;
		fwd_s fwd;
		dc_write_s wr;
		logic illegal;
		logic perr_p;
		logic pec_p;
	} core_s;

	core_s r_reg;
	core_s r_next;
	line_ev_s ev;
	logic [6:0] own_id;
	logic pec_on;
	logic addr_ok;
	logic par_ok;
	logic id_hit;
	logic more;

	line_monitor u_line (
		.ref_clk(ref_clk),
		.reset(reset),
		.scl(scl),
		.sda_in(sda_in),
		.ev(ev)
	);

	assign own_id = {local_identifier, host_identifier};
	assign pec_on = pec_enable & i3c_mode;
	assign par_ok = ^{r_reg.sh, ev.sda};
	assign more = (r_reg.tidx == TX_MSB) | ((r_reg.tidx == TX_LSB) & pec_on);

	always_comb begin
		addr_ok = 1'b0;
		if (!r_reg.err) begin // R4
			addr_ok = (r_reg.sh == BCAST_W) ||
				(r_reg.pend_cap && i3c_mode && r_reg.sh == {own_id, 1'b1}); // R3
		end
	end

	always_comb begin
		case (r_reg.amask)
			MASK_UNICAST: id_hit = (r_reg.sh[7:1] == own_id); // R18
			MASK_MULTICAST: id_hit = (r_reg.sh[7:4] == local_identifier); // R18
			MASK_BROADCAST: id_hit = 1'b1; // R18
			default: id_hit = 1'b0; // R21
		endcase
	end

	always_comb begin
		r_next = r_reg;
		r_next.fwd.valid = 1'b0;
		r_next.wr.valid = 1'b0;
		r_next.illegal = 1'b0;
		r_next.perr_p = 1'b0;
		r_next.pec_p = 1'b0;
		if (ev.stop) begin
			r_next.st = ST_IDLE;
			r_next.err = 1'b0;
			r_next.pend_cap = 1'b0;
			r_next.drive = 1'b0;
			r_next.cnt = '0;
		end else if (ev.start) begin
			r_next.st = ST_ADDR;
			r_next.cnt = '0;
			r_next.crc = CRC_INIT; // R2
			r_next.drive = 1'b0;
		end else if (r_reg.st != ST_IDLE && ev.fall) begin
			if (r_reg.st == ST_CAP) begin
				r_next.drive = 1'b1;
				if (r_reg.cnt != BYTE_BITS) begin
					r_next.sda_bit = r_reg.tx[7];
					r_next.tx = {r_reg.tx[6:0], 1'b0};
				end else begin
					r_next.sda_bit = more;
				end
			end else if (r_reg.st == ST_ADDR && r_reg.cnt == BYTE_BITS && addr_ok) begin
				r_next.drive = 1'b1;
				r_next.sda_bit = 1'b0;
			end else begin
				r_next.drive = 1'b0;
			end
		end else if (r_reg.st != ST_IDLE && ev.rise) begin
			if (r_reg.cnt != BYTE_BITS) begin
				r_next.sh = {r_reg.sh[6:0], ev.sda};
				r_next.cnt = r_reg.cnt + 4'h1;
			end else begin
				r_next.cnt = '0;
				case (r_reg.st)
					ST_SKIP: begin
						r_next.st = ST_SKIP;
					end
					ST_ADDR: begin
						if (!r_reg.drive) begin
							r_next.st = ST_SKIP;
						end else if (r_reg.sh == BCAST_W) begin
							r_next.st = ST_CODE; // R2
						end else begin
							r_next.st = ST_CAP; // R3
							r_next.tx = CAP_MSB; // R5
							r_next.tidx = TX_MSB;
							r_next.crc = crc8(crc8(r_reg.crc, r_reg.sh), CAP_MSB); // R2
						end
					end
					ST_CAP: begin
						if (r_reg.tidx == TX_MSB) begin
							r_next.tx = CAP_LSB; // R5
							r_next.tidx = TX_LSB;
							r_next.crc = crc8(r_reg.crc, CAP_LSB);
						end else if (r_reg.tidx == TX_LSB && pec_on) begin
							r_next.tx = r_reg.crc; // R3
							r_next.tidx = TX_PEC;
						end else begin
							r_next.st = ST_SKIP;
						end
					end
					default: begin
						if (!par_ok) begin
							r_next.err = 1'b1; // R4
							r_next.perr_p = 1'b1;
							r_next.st = ST_SKIP;
						end else begin
							r_next.crc = crc8(r_reg.crc, r_reg.sh);
							case (r_reg.st)
								ST_CODE: begin
									if (r_reg.sh == CODE_HOST_ID_SET) begin
										r_next.st = i3c_mode ? ST_SKIP : ST_HID; // R6
										r_next.illegal = i3c_mode; // R6
									end else if (r_reg.sh == CODE_DEVICE_CONTROL) begin
										r_next.st = ST_DC_CTL; // R14
									end else if (r_reg.sh == capability_code && i3c_mode) begin
										r_next.pend_cap = 1'b1; // R1
										r_next.st = pec_on ? ST_PEC : ST_SKIP;
									end else begin
										r_next.st = ST_SKIP; // R1
									end
								end
								ST_HID: begin
									r_next.fwd.valid = 1'b1; // R13
									r_next.fwd.data = {r_reg.sh[7:4], host_identifier, r_reg.sh[0]}; // R10
									r_next.fwd.t_bit = ~^{r_reg.sh[7:4], host_identifier, r_reg.sh[0]}; // R11
									r_next.hid_done = 1'b1; // R8
									r_next.st = ST_SKIP; // R12
								end
								ST_DC_CTL: begin
									r_next.amask = r_reg.sh[7:5]; // R15
									r_next.idx = r_reg.sh[4:3];
									r_next.bl = r_reg.sh[2:1];
									r_next.rmode = r_reg.sh[0];
									r_next.nb = '0;
									r_next.st = ST_DC_ID;
								end
								ST_DC_ID: begin
									r_next.st = id_hit ? ST_DC_PAY : ST_SKIP; // R21
								end
								ST_DC_PAY: begin
									r_next.wr.valid = 1'b1; // R19
									r_next.wr.index = r_reg.idx;
									r_next.wr.data = r_reg.sh;
									r_next.wr.reg_mode = r_reg.rmode;
									if (pec_on && !r_reg.rmode && r_reg.nb == r_reg.bl) begin
										r_next.st = ST_PEC; // R20
									end else if (r_reg.idx == LAST_BYTE) begin
										r_next.st = ST_SKIP; // R19
									end else begin
										r_next.idx = r_reg.idx + 2'h1;
										r_next.nb = r_reg.nb + 2'h1;
									end
								end
								ST_PEC: begin
									r_next.st = ST_SKIP;
									if (r_reg.sh != r_reg.crc) begin
										r_next.err = 1'b1; // R4
										r_next.pec_p = 1'b1;
									end
								end
								default: begin
									r_next.st = ST_SKIP;
								end
							endcase
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign sda_out = r_reg.sda_bit;
	assign sda_oe_n = ~r_reg.drive;
	assign hid_translate = ~r_reg.hid_done;
	assign fwd = r_reg.fwd;
	assign wr = r_reg.wr;
	assign illegal_cmd = r_reg.illegal;
	assign parity_error = r_reg.perr_p;
	assign pec_error = r_reg.pec_p;

	property p_cap_i3c_only;
		@(posedge ref_clk) disable iff (reset)
		(r_reg.st == ST_CAP) |-> r_reg.pend_cap && i3c_mode;
	endproperty
	a_cap_i3c_only: assert property (p_cap_i3c_only) else $error("capability read without query"); // R1

	property p_crc_restart;
		@(posedge ref_clk) disable iff (reset)
		ev.start && !ev.stop |=> r_reg.crc == CRC_INIT && r_reg.st == ST_ADDR;
	endproperty
	a_crc_restart: assert property (p_crc_restart) else $error("checksum not restarted"); // R2

	property p_chain_nack;
		@(posedge ref_clk) disable iff (reset)
		r_reg.err && r_reg.st == ST_ADDR && !ev.start && !ev.stop |=> sda_oe_n;
	endproperty
	a_chain_nack: assert property (p_chain_nack) else $error("address acked after error"); // R4

	property p_cap_msb;
		@(posedge ref_clk) disable iff (reset)
		$rose(r_reg.st == ST_CAP) |-> r_reg.tx == CAP_MSB && r_reg.tidx == TX_MSB;
	endproperty
	a_cap_msb: assert property (p_cap_msb) else $error("wrong capability byte"); // R5

	property p_illegal_i3c;
		@(posedge ref_clk) disable iff (reset)
		illegal_cmd |-> $past(i3c_mode) && $past(r_reg.sh) == CODE_HOST_ID_SET;
	endproperty
	a_illegal_i3c: assert property (p_illegal_i3c) else $error("illegal flag outside I3C"); // R6

	property p_hid_stop;
		@(posedge ref_clk) disable iff (reset)
		fwd.valid |-> !hid_translate ##1 !hid_translate;
	endproperty
	a_hid_stop: assert property (p_hid_stop) else $error("translation still on"); // R8

	property p_fwd_bits;
		@(posedge ref_clk) disable iff (reset)
		fwd.valid |-> fwd.data[3:1] == host_identifier &&
			fwd.data[7:4] == $past(r_reg.sh[7:4]) && fwd.data[0] == $past(r_reg.sh[0]);
	endproperty
	a_fwd_bits: assert property (p_fwd_bits) else $error("forwarded byte wrong"); // R10

	property p_fwd_parity;
		@(posedge ref_clk) disable iff (reset)
		fwd.valid |-> ^{fwd.data, fwd.t_bit};
	endproperty
	a_fwd_parity: assert property (p_fwd_parity) else $error("forwarded parity wrong"); // R11

	property p_hid_no_pec;
		@(posedge ref_clk) disable iff (reset)
		r_reg.st == ST_HID |=> r_reg.st != ST_PEC;
	endproperty
	a_hid_no_pec: assert property (p_hid_no_pec) else $error("checksum after identifier set"); // R12

	property p_wr_order;
		@(posedge ref_clk) disable iff (reset)
		wr.valid && wr.index == LAST_BYTE |=> r_reg.st != ST_DC_PAY;
	endproperty
	a_wr_order: assert property (p_wr_order) else $error("payload past last byte"); // R19

	c_fwd: cover property (@(posedge ref_clk) disable iff (reset) fwd.valid);
	c_wr: cover property (@(posedge ref_clk) disable iff (reset) wr.valid);
	c_cap: cover property (@(posedge ref_clk) disable iff (reset) r_reg.tidx == TX_PEC);
	c_pec_err: cover property (@(posedge ref_clk) disable iff (reset) pec_error);

endmodule : hub_ccc_capability_hid_device_control_cmd

// ### pkg/hub_ccc_pkg.sv
// Shared constants, types and the checksum function of the hub command interpreter.
package hub_ccc_pkg;

	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned I2C_MAX_HZ = 1_000_000;
	localparam int unsigned I2C_MIN_SCL_CYC = (CLK_HZ + I2C_MAX_HZ - 1) / I2C_MAX_HZ;

	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] BCAST_W = 8'hfc;
	localparam logic [7:0] CODE_HOST_ID_SET = 8'h61;
	localparam logic [7:0] CODE_DEVICE_CONTROL = 8'h62;
	localparam logic [7:0] CAP_MSB = 8'h04;
	localparam logic [7:0] CAP_LSB = 8'h00;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [2:0] MASK_UNICAST = 3'h0;
	localparam logic [2:0] MASK_MULTICAST = 3'h3;
	localparam logic [2:0] MASK_BROADCAST = 3'h7;
	localparam logic [1:0] LAST_BYTE = 2'h3;
	localparam logic [1:0] TX_MSB = 2'h0;
	localparam logic [1:0] TX_LSB = 2'h1;
	localparam logic [1:0] TX_PEC = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_CODE = 4'h3,
		ST_DC_CTL = 4'h2,
		ST_DC_ID = 4'h6,
		ST_DC_PAY = 4'h7,
		ST_PEC = 4'h5,
		ST_HID = 4'h4,
		ST_CAP = 4'hc,
		ST_SKIP = 4'hd
	} cmd_state_e;

	typedef struct packed {
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic sda;
	} line_ev_s;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
	} line_sync_s;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic t_bit;
	} fwd_s;

	typedef struct packed {
		logic valid;
		logic [1:0] index;
		logic [7:0] data;
		logic reg_mode;
	} dc_write_s;

	function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc8

endpackage : hub_ccc_pkg

// ### rtl/line_monitor.sv
// Pin synchroniser and bus condition detector for the host serial lines.
module line_monitor
	import hub_ccc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda_in,
	output line_ev_s ev
);

	line_sync_s r_reg;
	line_sync_s r_next;

	always_comb begin
		r_next.s1 = {scl, sda_in};
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			// Both lines idle high, so the history starts high and no false edge follows reset.
			r_reg <= '1;
		end else begin
			r_reg <= r_next;
		end
	end

	always_comb begin
		ev.rise = r_reg.s2[1] & ~r_reg.s3[1];
		ev.fall = ~r_reg.s2[1] & r_reg.s3[1];
		ev.start = r_reg.s2[1] & r_reg.s3[1] & ~r_reg.s2[0] & r_reg.s3[0];
		ev.stop = r_reg.s2[1] & r_reg.s3[1] & r_reg.s2[0] & ~r_reg.s3[0];
		ev.sda = r_reg.s2[0];
	end

endmodule : line_monitor

// ### test/host_model.sv
// Host controller model that drives the serial clock and data lines of the hub.
module host_model
	import hub_ccc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic i3c_mode,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	output logic scl,
	output logic sda_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sda_h = 1'b1;
	logic busy = 1'b0;
	initial scl = 1'b1;
	// The data line has a pull-up, so a released line reads high.
	assign sda_in = sda_h & (sda_oe_n | sda_out);

	task go(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : go

	function int half();
		return i3c_mode ? 4 : int'(I2C_MIN_SCL_CYC / 2);
	endfunction : half

	task bit_io(input logic b, output logic s);
		scl <= 1'b0;
		go(2);
		sda_h <= b;
		go(half() - 2);
		scl <= 1'b1;
		go(2);
		s = sda_in;
		go(half() - 2);
	endtask : bit_io

	task start();
		if (busy) begin
			scl <= 1'b0;
			go(2);
			sda_h <= 1'b1;
			go(half());
			scl <= 1'b1;
			go(half());
		end
		sda_h <= 1'b0;
		go(half());
		busy = 1'b1;
	endtask : start

	task stop();
		scl <= 1'b0;
		go(2);
		sda_h <= 1'b0;
		go(half());
		scl <= 1'b1;
		go(half());
		sda_h <= 1'b1;
		go(half());
		busy = 1'b0;
	endtask : stop

	task xfer(input logic [7:0] d, input logic nine, output logic [7:0] r, output logic t);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(nine, t);
	endtask : xfer
endmodule : host_model

// ### test/hub_ccc_capability_hid_device_control_cmd_test.sv
// Self-checking testbench of the hub command interpreter.
module hub_ccc_capability_hid_device_control_cmd_test
	import hub_ccc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CAP = 8'he0;
	logic ref_clk = 1'b0;
	logic reset, scl, sda_in, sda_out, sda_oe_n, i3c_mode, pec_enable;
	logic hid_translate, illegal_cmd, parity_error, pec_error;
	logic [2:0] host_identifier;
	logic [3:0] local_identifier;
	fwd_s fwd;
	fwd_s fwd_last;
	dc_write_s wr;
	dc_write_s wr_q[$];
	int failures = 0;
	int checks_done = 0;
	int fwd_n = 0, ill_n = 0, par_n = 0, pec_n = 0;

	hub_ccc_capability_hid_device_control_cmd #(.capability_code(CAP)) uut (.ref_clk, .reset, .scl,
		.sda_in, .sda_out, .sda_oe_n, .i3c_mode, .pec_enable, .host_identifier,
		.local_identifier, .hid_translate, .fwd, .wr, .illegal_cmd, .parity_error, .pec_error);
	host_model host (.ref_clk, .i3c_mode, .sda_out, .sda_oe_n, .scl, .sda_in);

	initial forever #12.5 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		if (fwd.valid === 1'b1) begin
			fwd_n++;
			fwd_last = fwd;
		end
		if (wr.valid === 1'b1) wr_q.push_back(wr);
		if (illegal_cmd === 1'b1) ill_n++;
		if (parity_error === 1'b1) par_n++;
		if (pec_error === 1'b1) pec_n++;
	end

	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task end_of_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] v;
		v = c ^ d;
		for (int i = 0; i < 8; i++) begin
			v = v[7] ? ((v << 1) ^ CRC_POLY) : (v << 1);
		end
		return v;
	endfunction : crc_step

	task set_mode(input logic m, input logic p);
		@(posedge ref_clk);
		i3c_mode <= m;
		pec_enable <= p;
		@(posedge ref_clk);
	endtask : set_mode

	task wt(input logic [7:0] d);
		logic [7:0] r;
		logic n;
		host.xfer(d, ~^d, r, n);
	endtask : wt

	task addr(input logic [7:0] a, input logic exp, input string what);
		logic [7:0] r;
		logic n;
		host.xfer(a, 1'b1, r, n);
		check(what, n, exp);
	endtask : addr

	task rd(input logic [7:0] d, input logic t, input string what);
		logic [7:0] r;
		logic n;
		host.xfer(8'hff, 1'b1, r, n);
		check(what, r, d);
		check(what, n, t);
	endtask : rd

	task test_reset();
		check("data enable", sda_oe_n, 1'b1);
		check("translate", hid_translate, 1'b1);
		$display("reset test done");
	endtask : test_reset

	task test_cap();
		logic [7:0] c;
		logic [7:0] id;
		for (int p = 0; p < 2; p++) begin
			set_mode(1'b1, p[0]);
			id = {local_identifier, host_identifier, 1'b1};
			host.start();
			addr(BCAST_W, 1'b0, "broadcast ack");
			wt(CAP);
			if (p == 1) wt(crc_step(8'h00, CAP));
			host.start();
			addr(id, 1'b0, "target ack");
			c = crc_step(crc_step(crc_step(8'h00, id), 8'h04), 8'h00);
			rd(8'h04, 1'b1, "upper capability");
			rd(8'h00, p[0], "lower capability");
			if (p == 1) rd(c, 1'b0, "returned checksum");
			host.stop();
		end
		check("checksum errors", 16'(pec_n), 16'h0);
		$display("capability query test done");
	endtask : test_cap

	task test_cap_i2c();
		set_mode(1'b0, 1'b0);
		host.start();
		addr(BCAST_W, 1'b0, "broadcast ack");
		wt(CAP);
		host.start();
		addr({local_identifier, host_identifier, 1'b1}, 1'b1, "ignored query");
		host.stop();
		$display("capability in two-wire mode test done");
	endtask : test_cap_i2c

	task test_hid_i3c();
		int n;
		n = ill_n;
		set_mode(1'b1, 1'b0);
		host.start();
		addr(BCAST_W, 1'b0, "broadcast ack");
		wt(CODE_HOST_ID_SET);
		wt(8'h00);
		host.stop();
		check("illegal flag", 16'(ill_n), 16'(n + 1));
		check("forward count", 16'(fwd_n), 16'h0);
		check("translate", hid_translate, 1'b1);
		$display("illegal identifier set test done");
	endtask : test_hid_i3c

	task test_hid_i2c();
		set_mode(1'b0, 1'b1);
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk);
			host_identifier <= k[0] ? 3'h2 : 3'h5;
			host.start();
			addr(BCAST_W, 1'b0, "broadcast ack");
			wt(CODE_HOST_ID_SET);
			wt(8'h00);
			host.stop();
			check("forward count", 16'(fwd_n), 16'(k + 1));
			check("forward data", fwd_last.data, {4'h0, host_identifier, 1'b0});
			check("forward parity", fwd_last.t_bit, ~^{host_identifier});
			check("translate", hid_translate, 1'b0);
		end
		check("checksum errors", 16'(pec_n), 16'h0);
		$display("identifier set test done");
	endtask : test_hid_i2c

	task test_device_control_cmd();
		logic [2:0] masks[6] = '{3'h0, 3'h0, 3'h3, 3'h3, 3'h7, 3'h1};
		logic [6:0] ids[6] = '{7'h55, 7'h54, 7'h50, 7'h58, 7'h00, 7'h55};
		int hits[6] = '{2, 0, 2, 0, 2, 0};
		@(posedge ref_clk);
		host_identifier <= 3'h5;
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 6; i++) begin
				set_mode(m[0], 1'b0);
				wr_q.delete();
				host.start();
				addr(BCAST_W, 1'b0, "broadcast ack");
				wt(CODE_DEVICE_CONTROL);
				wt({masks[i], 2'h2, 2'h1, 1'b0});
				wt({ids[i], 1'b0});
				wt(8'ha2);
				wt(8'ha3);
				host.stop();
				check("write count", 16'(wr_q.size()), 16'(hits[i]));
				if (hits[i] == 2) begin
					check("first index", wr_q[0].index, 2'h2);
					check("first data", wr_q[0].data, 8'ha2);
					check("last index", wr_q[1].index, 2'h3);
					check("register mode", wr_q[1].reg_mode, 1'b0);
				end
			end
		end
		$display("device control test done");
	endtask : test_device_control_cmd

	task test_parity();
		int n;
		logic [7:0] r;
		logic t;
		n = par_n;
		set_mode(1'b1, 1'b0);
		host.start();
		addr(BCAST_W, 1'b0, "broadcast ack");
		host.xfer(CODE_DEVICE_CONTROL, ^CODE_DEVICE_CONTROL, r, t);
		host.start();
		addr(BCAST_W, 1'b1, "address after parity error");
		host.stop();
		check("parity flag", 16'(par_n), 16'(n + 1));
		host.start();
		addr(BCAST_W, 1'b0, "address after stop");
		host.stop();
		$display("parity error test done");
	endtask : test_parity

	task test_device_control_cmd_pec();
		logic [7:0] c;
		int n;
		n = pec_n;
		set_mode(1'b1, 1'b1);
		for (int e = 0; e < 2; e++) begin
			wr_q.delete();
			c = crc_step(crc_step(crc_step(crc_step(crc_step(8'h00, CODE_DEVICE_CONTROL),
				8'he2), 8'h00), 8'h11), 8'h22);
			host.start();
			addr(BCAST_W, 1'b0, "broadcast ack");
			wt(CODE_DEVICE_CONTROL);
			wt(8'he2);
			wt(8'h00);
			wt(8'h11);
			wt(8'h22);
			wt(c ^ 8'(e));
			host.start();
			addr(BCAST_W, e[0], "address after checksum");
			host.stop();
			check("write count", 16'(wr_q.size()), 16'h2);
			check("checksum errors", 16'(pec_n), 16'(n + e));
		end
		$display("device control checksum test done");
	endtask : test_device_control_cmd_pec

	task test_device_control_cmd_reg();
		set_mode(1'b1, 1'b0);
		wr_q.delete();
		host.start();
		addr(BCAST_W, 1'b0, "broadcast ack");
		wt(CODE_DEVICE_CONTROL);
		wt(8'he1);
		wt(8'h00);
		wt(8'h33);
		wt(8'h44);
		host.stop();
		check("write count", 16'(wr_q.size()), 16'h2);
		check("first data", wr_q[0].data, 8'h33);
		check("second index", wr_q[1].index, 2'h1);
		check("register mode", wr_q[1].reg_mode, 1'b1);
		$display("device control register mode test done");
	endtask : test_device_control_cmd_reg

	initial begin
		reset = 1'b1;
		i3c_mode = 1'b0;
		pec_enable = 1'b0;
		host_identifier = 3'h5;
		local_identifier = 4'ha;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (4) @(posedge ref_clk);
		test_reset();
		test_cap();
		test_cap_i2c();
		test_hid_i3c();
		test_hid_i2c();
		test_device_control_cmd();
		test_device_control_cmd_pec();
		test_device_control_cmd_reg();
		test_parity();
		end_of_test();
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		failures++;
		$display("wrong value run time expected end seen hang");
		end_of_test();
	end
endmodule : hub_ccc_capability_hid_device_control_cmd_test
